// ==== verilog/term_ctrl_pkg.sv ====
// Package of constants and types shared by both ends of the termination link.
package term_ctrl_pkg;

	// ==================================================================
	// Mode register field positions
	// ==================================================================
	// Nominal strength select bits in mode register one.
	localparam int NOM_SEL_BIT0       = 2;
	localparam int NOM_SEL_BIT1       = 6;
	localparam int NOM_SEL_BIT2       = 9;
	// Additive latency field in mode register one.
	localparam int ADD_LAT_LSB        = 3;
	// Write strength select bits in mode register two.
	localparam int WR_SEL_LSB         = 9;
	// Cas write latency field in mode register two.
	localparam int CWL_LSB            = 3;
	// Freeze select bit in mode register zero.
	localparam int DLL_KEEP_BIT       = 12;

	// ==================================================================
	// Fixed timing counts in clocks
	// ==================================================================
	// Offset subtracted from the write latency for the pin latencies.
	localparam int LAT_OFFSET         = 2;
	// Minimum pin high time after assertion or a chop-four write.
	localparam int TERM_PIN_MIN_HIGH_SHORT = 4;
	// Minimum pin high time after a full-length write.
	localparam int TERM_PIN_MIN_HIGH_LONG  = 6;
	// Extra clocks after the off latency for the return to nominal.
	localparam int CWN_CHOP_EXTRA     = 4;
	localparam int CWN_FULL_EXTRA     = 6;
	// Width of latency counters and delay line depth.
	localparam int LAT_W              = 6;
	localparam int LINE_DEPTH         = 32;

	// ==================================================================
	// Register map of the controller, one aligned word each
	// ==================================================================
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_MR0    = 8'h04;
	localparam logic [7:0] REG_MR1    = 8'h08;
	localparam logic [7:0] REG_MR2    = 8'h0C;
	localparam logic [7:0] REG_CMD    = 8'h10;
	localparam logic [7:0] REG_STAT   = 8'h14;
	// Control register field positions.
	localparam int CTRL_DLL_OFF       = 0;
	localparam int CTRL_FROZEN        = 1;
	// Command register field positions.
	localparam int CMD_CODE_LSB       = 0;
	localparam int CMD_CHOP           = 4;
	localparam int CMD_TERM           = 5;
	// Status register field positions.
	localparam int STAT_BUSY          = 0;
	localparam int STAT_PIN           = 1;

	// Bus command codes.
	typedef enum logic [2:0] {
		CMD_NONE, CMD_WRITE, CMD_READ, CMD_MRS0, CMD_MRS1, CMD_MRS2, CMD_PIN
	} cmd_code_e;

	// Strength reported by the device.
	typedef enum logic [1:0] { STR_OFF, STR_NOMINAL, STR_WRITE } strength_e;

endpackage : term_ctrl_pkg

// ==== verilog/term_link_if.sv ====
// Interface joining the memory controller and the termination logic.
`timescale 1ns/100ps
`default_nettype none
interface term_link_if;
	logic        termPin;   // Termination request pin.
	logic        writeCmd;  // One-cycle write command strobe.
	logic        readCmd;   // One-cycle read command strobe.
	logic        chopFour;  // Write is burst chop four when high.
	logic        mrsValid;  // One-cycle mode register set strobe.
	logic [1:0]  mrsSel;    // Which mode register is written.
	logic [15:0] mrsData;   // Mode register set value.
	logic        dllFrozen; // Device in precharge power-down with DLL frozen.
	logic        dllOff;    // Device runs with DLL off.
	modport device (input termPin, writeCmd, readCmd, chopFour, mrsValid,
		mrsSel, mrsData, dllFrozen, dllOff);
	modport ctrl (output termPin, writeCmd, readCmd, chopFour, mrsValid,
		mrsSel, mrsData, dllFrozen, dllOff);
endinterface : term_link_if
`default_nettype wire

// ==== verilog/dram_term_device.sv ====
// Termination control logic of the memory device end.
// Notes on behaviour
// [RL1] Synchronous timing while DLL is on.
// [RL2] Controller keeps termination off with DLL off.
// [RL3] Pin on/off after write latency minus two.
// [RL4] Latency includes additive latency: cwl+al-2.
// [RL5] Controller holds pin high four clocks.
// [RL6] Pin held 4 or 6 after write.
// [RL7] Controller drops pin around reads.
// [RL8] Never terminate while driving read data.
// [RL9] Dynamic switching when either write bit set.
// [RL10] Strengths come from mode registers one, two.
// [RL11] Nominal strength when no write active.
// [RL12] Write strength write latency minus two later.
// [RL13] Back to nominal off latency plus 4/6.
// [RL14] Controller clears write bits with DLL off.
// [RL15] Pin alone decides on/off, unless disabled.
// [RL16] Frozen DLL: no additive latency delay.
// [RL17] New write restarts strength counters.
`timescale 1ns/100ps
`default_nettype none
module dram_term_device (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rstn,
	// Link from the controller.
	term_link_if.device           link,
	// Read data input and device status outputs.
	input  wire logic             readDriving,
	output logic                  termOn,
	output term_ctrl_pkg::strength_e strength,
	output logic [2:0]            nomSel,
	output logic [1:0]            wrSel
);
	// ==================================================================
	// Mode registers
	// ==================================================================
	logic [15:0] modeRegZero, modeRegOne, modeRegTwo;  // Stored values.
	logic [15:0] next_modeRegZero, next_modeRegOne, next_modeRegTwo;
	logic [4:0]  addLat;       // Additive latency in clocks.
	logic [4:0]  casWriteLat;  // Cas write latency in clocks.
	logic [5:0]  termLat;      // Pin latency in clocks.
	logic        dynEnable;    // Dynamic switching enabled.
	logic        termEnabled;  // Any strength selected.
	logic        asyncTiming;  // Frozen DLL: no additive latency.
	// The delay line holds 32 samples; the largest latency is 13.

	// Mode register set capture.
	// An unused select code stores nothing.
	always_comb begin
		next_modeRegZero = modeRegZero;
		next_modeRegOne  = modeRegOne;
		next_modeRegTwo  = modeRegTwo;
		if (link.mrsValid) begin
			case (link.mrsSel)
				2'h0:    next_modeRegZero = link.mrsData;
				2'h1:    next_modeRegOne  = link.mrsData;
				2'h2:    next_modeRegTwo  = link.mrsData;
				default: next_modeRegZero = modeRegZero;
			endcase
		end
	end

	// Mode register storage.
	// Reset clears every select, so termination stays off until set.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			modeRegZero <= 16'h0000;
			modeRegOne  <= 16'h0000;
			modeRegTwo  <= 16'h0000;
		end else begin
			modeRegZero <= next_modeRegZero;
			modeRegOne  <= next_modeRegOne;
			modeRegTwo  <= next_modeRegTwo;
		end
	end

	// Field decode.
	// Decoded fields feed the latency and enable logic below.
	always_comb begin
		nomSel = {modeRegOne[term_ctrl_pkg::NOM_SEL_BIT2],
			modeRegOne[term_ctrl_pkg::NOM_SEL_BIT1],
			modeRegOne[term_ctrl_pkg::NOM_SEL_BIT0]};  // RL10
		wrSel = modeRegTwo[term_ctrl_pkg::WR_SEL_LSB +: 2];  // RL10
		addLat = {3'h0, modeRegOne[term_ctrl_pkg::ADD_LAT_LSB +: 2]};
		// Cas write latency is coded from five clocks upward.
		casWriteLat = {2'h0, modeRegTwo[term_ctrl_pkg::CWL_LSB +: 3]} + 5'h05;
		// Frozen DLL drops the additive latency from the pin path.
		// The DLL counts as frozen only while the keep bit is clear.
		asyncTiming = link.dllFrozen && !modeRegZero[term_ctrl_pkg::DLL_KEEP_BIT];  // RL1
		if (asyncTiming) begin
			termLat = 6'(casWriteLat) - 6'(term_ctrl_pkg::LAT_OFFSET);  // RL16
		end else begin
			termLat = 6'(casWriteLat) + 6'(addLat) - 6'(term_ctrl_pkg::LAT_OFFSET);  // RL4
		end
		dynEnable = (wrSel != 2'h0);  // RL9
		termEnabled = (nomSel != 3'h0) || dynEnable;
	end

	// ==================================================================
	// Pin delay line
	// ==================================================================
	logic [term_ctrl_pkg::LINE_DEPTH-1:0] pinLine, next_pinLine;  // Sampled pin history.
	logic delayedPin;  // Pin seen termLat clocks ago.

	// Shift the sampled pin each rising edge.
	// Index k holds the pin sampled k+1 edges ago.
	always_comb begin
		next_pinLine = {pinLine[term_ctrl_pkg::LINE_DEPTH-2:0], link.termPin};  // RL3
		// Latency counts from the sampling edge; index zero is one clock later.
		// A zero latency bypasses the line so the index cannot underflow.
		delayedPin = (termLat == 6'h00) ? link.termPin : pinLine[termLat[4:0] - 5'h01];
	end

	// Delay line register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pinLine <= '0;
		end else begin
			pinLine <= next_pinLine;
		end
	end

	// ==================================================================
	// Strength switching counters
	// ==================================================================
	logic [5:0] cnwCount, next_cnwCount;  // Clocks until write strength.
	logic [5:0] cwnCount, next_cwnCount;  // Clocks until nominal strength.
	logic       writeStr, next_writeStr;  // Write strength selected.

	// Counters load on each write with dynamic switching enabled and dllOff low, so the newest write governs.
	// cwnCount always outlasts cnwCount, so set and clear never meet.
	// A write without dynamic switching leaves the strength nominal.
	always_comb begin
		next_cnwCount = cnwCount;
		next_cwnCount = cwnCount;
		next_writeStr = writeStr;
		if (cnwCount != 6'h00) begin
			next_cnwCount = cnwCount - 6'h01;
			if (cnwCount == 6'h01) begin
				next_writeStr = 1'b1;  // RL12
			end
		end
		if (cwnCount != 6'h00) begin
			next_cwnCount = cwnCount - 6'h01;
			if (cwnCount == 6'h01) begin
				next_writeStr = 1'b0;  // RL13
			end
		end
		if (link.writeCmd && dynEnable && !link.dllOff) begin
			next_cnwCount = termLat;  // RL17
			next_cwnCount = termLat + (link.chopFour ?
				6'(term_ctrl_pkg::CWN_CHOP_EXTRA) : 6'(term_ctrl_pkg::CWN_FULL_EXTRA));  // RL13
			if (termLat == 6'h00) begin
				next_writeStr = 1'b1;
			end
		end
		if (!dynEnable) begin
			next_writeStr = 1'b0;  // RL11
		end
	end

	// Counter registers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnwCount <= 6'h00;
			cwnCount <= 6'h00;
			writeStr <= 1'b0;
		end else begin
			cnwCount <= next_cnwCount;
			cwnCount <= next_cwnCount;
			writeStr <= next_writeStr;
		end
	end

	// ==================================================================
	// Termination output
	// ==================================================================
	logic next_termOn;  // Next termination state.
	term_ctrl_pkg::strength_e next_strength;

	// The pin decides on or off, gated by the enables, dllOff and read data; commands only pick strength.
	// Read data on the bus drops termination at the next edge, without the pin latency.
	// Strength uses next_writeStr so it changes on the counters' edge.
	always_comb begin
		next_termOn = delayedPin && termEnabled && !link.dllOff  // RL15 RL1
			&& !readDriving;  // RL8
		if (!next_termOn) begin
			next_strength = term_ctrl_pkg::STR_OFF;
		end else if (next_writeStr) begin  // RL12
			next_strength = term_ctrl_pkg::STR_WRITE;
		end else begin
			next_strength = term_ctrl_pkg::STR_NOMINAL;  // RL11
		end
	end

	// Output registers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			termOn   <= 1'b0;
			strength <= term_ctrl_pkg::STR_OFF;
		end else begin
			termOn   <= next_termOn;
			strength <= next_strength;
		end
	end

endmodule : dram_term_device
`default_nettype wire

// ==== verilog/dram_term_ctrl.sv ====
// Memory controller end: APB registers drive the termination pin and commands.
`timescale 1ns/100ps
`default_nettype none
module dram_term_ctrl (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rstn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Link to the device.
	term_link_if.ctrl        link
);
	// ==================================================================
	// Registers
	// ==================================================================
	logic        dllOff, dllFrozen, pinHigh;   // Control state.
	logic [15:0] mr0, mr1, mr2;                // Shadow mode registers.
	logic [2:0]  holdCnt;                      // Clocks the pin must stay high.
	logic [2:0]  readGap;                      // Clocks the pin stays low after a read.
	logic [31:0] next_prdata;
	logic        access, busy;

	assign pready  = 1'b1;
	assign access  = psel && penable;
	assign busy    = (holdCnt != 3'h0) || (readGap != 3'h0);
	assign pslverr = access && (paddr > term_ctrl_pkg::REG_STAT);

	// Read data mux.
	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			term_ctrl_pkg::REG_CTRL: next_prdata = {30'h0, dllFrozen, dllOff};
			term_ctrl_pkg::REG_MR0:  next_prdata = {16'h0, mr0};
			term_ctrl_pkg::REG_MR1:  next_prdata = {16'h0, mr1};
			term_ctrl_pkg::REG_MR2:  next_prdata = {16'h0, mr2};
			term_ctrl_pkg::REG_STAT: next_prdata = {30'h0, pinHigh, busy};
			default:                 next_prdata = 32'h0000_0000;
		endcase
	end
	// Read data is taken in the setup cycle and stands through the access.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= next_prdata;
		end
	end

	// Register writes, command issue and pin hold timing.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dllOff <= 1'b0;
			dllFrozen <= 1'b0;
			pinHigh <= 1'b0;
			mr0 <= 16'h0000;
			mr1 <= 16'h0000;
			mr2 <= 16'h0000;
			holdCnt <= 3'h0;
			readGap <= 3'h0;
			link.writeCmd <= 1'b0;
			link.readCmd <= 1'b0;
			link.chopFour <= 1'b0;
			link.mrsValid <= 1'b0;
			link.mrsSel <= 2'h0;
			link.mrsData <= 16'h0000;
		end else begin
			link.writeCmd <= 1'b0;
			link.readCmd <= 1'b0;
			link.mrsValid <= 1'b0;
			if (holdCnt != 3'h0) holdCnt <= holdCnt - 3'h1;
			if (readGap != 3'h0) readGap <= readGap - 3'h1;
			if (access && pwrite && paddr == term_ctrl_pkg::REG_CTRL) begin
				dllOff <= pwdata[term_ctrl_pkg::CTRL_DLL_OFF];
				dllFrozen <= pwdata[term_ctrl_pkg::CTRL_FROZEN];
				if (pwdata[term_ctrl_pkg::CTRL_DLL_OFF]) begin
					pinHigh <= 1'b0;  // RL2
					mr1[term_ctrl_pkg::NOM_SEL_BIT0] <= 1'b0;
					mr1[term_ctrl_pkg::NOM_SEL_BIT1] <= 1'b0;
					mr1[term_ctrl_pkg::NOM_SEL_BIT2] <= 1'b0;
					mr2[term_ctrl_pkg::WR_SEL_LSB +: 2] <= 2'h0;  // RL14
					link.mrsValid <= 1'b1;
					link.mrsSel <= 2'h2;
					link.mrsData <= mr2 & ~(16'h0003 << term_ctrl_pkg::WR_SEL_LSB);  // RL14
				end
			end
			if (access && pwrite) begin
				case (paddr)
					term_ctrl_pkg::REG_MR0: mr0 <= pwdata[15:0];
					term_ctrl_pkg::REG_MR1: mr1 <= pwdata[15:0];
					term_ctrl_pkg::REG_MR2: mr2 <= pwdata[15:0];
					default: ;
				endcase
			end
			if (access && pwrite && paddr == term_ctrl_pkg::REG_CMD) begin
				case (term_ctrl_pkg::cmd_code_e'(pwdata[2:0]))
					term_ctrl_pkg::CMD_WRITE: begin
						link.writeCmd <= 1'b1;
						link.chopFour <= pwdata[term_ctrl_pkg::CMD_CHOP];
						if (pinHigh) begin
							holdCnt <= pwdata[term_ctrl_pkg::CMD_CHOP] ?  // RL6
								3'(term_ctrl_pkg::TERM_PIN_MIN_HIGH_SHORT) :
								3'(term_ctrl_pkg::TERM_PIN_MIN_HIGH_LONG);
						end
					end
					term_ctrl_pkg::CMD_READ: begin
						link.readCmd <= 1'b1;
						pinHigh <= 1'b0;  // RL7
						readGap <= 3'h4;
					end
					term_ctrl_pkg::CMD_MRS0: begin
						link.mrsValid <= 1'b1; link.mrsSel <= 2'h0; link.mrsData <= mr0;
					end
					term_ctrl_pkg::CMD_MRS1: begin
						link.mrsValid <= 1'b1; link.mrsSel <= 2'h1; link.mrsData <= mr1;
					end
					term_ctrl_pkg::CMD_MRS2: begin
						link.mrsValid <= 1'b1; link.mrsSel <= 2'h2; link.mrsData <= mr2;
					end
					term_ctrl_pkg::CMD_PIN: begin
						if (pwdata[term_ctrl_pkg::CMD_TERM] && !dllOff && readGap == 3'h0
							&& !pinHigh) begin
							pinHigh <= 1'b1;
							holdCnt <= 3'(term_ctrl_pkg::TERM_PIN_MIN_HIGH_SHORT);  // RL5
						end else if (!pwdata[term_ctrl_pkg::CMD_TERM] && holdCnt <= 3'h1) begin
							pinHigh <= 1'b0;
						end
					end
					default: ;
				endcase
			end
		end
	end

	assign link.termPin   = pinHigh;
	assign link.dllOff    = dllOff;
	assign link.dllFrozen = dllFrozen;

endmodule : dram_term_ctrl
`default_nettype wire

// ==== verification/dram_on_die_termination_ctrl_props.sv ====
// Concurrent checks on the termination link and on the device outputs.
`timescale 1ns/100ps
`default_nettype none
module dram_on_die_termination_ctrl_props (
	// Clock and reset.
	input wire logic                      clk,
	input wire logic                      rstn,
	// Link signals.
	input wire logic                      termPin,
	input wire logic                      writeCmd,
	input wire logic                      readCmd,
	input wire logic                      chopFour,
	input wire logic                      mrsValid,
	input wire logic [1:0]                mrsSel,
	input wire logic [15:0]               mrsData,
	input wire logic                      dllFrozen,
	input wire logic                      dllOff,
	// Device side signals.
	input wire logic                      readDriving,
	input wire logic                      termOn,
	input wire term_ctrl_pkg::strength_e  strength
);
	// ==================================================================
	// Helper state
	// ==================================================================
	logic [15:0] mr1, next_mr1;         // Copy of mode register one.
	logic [15:0] mr2, next_mr2;         // Copy of mode register two.
	logic [15:0] pinHist, next_pinHist; // Earlier pin samples, newest in bit 0.
	logic [15:0] wrHist, next_wrHist;   // Earlier write strobes, newest in bit 0.
	logic [7:0]  sinceWr, next_sinceWr; // Clocks since the last write, saturating.
	int          lat;                   // Turn-on and turn-off latency in clocks.
	logic        nomOn;                 // Nominal strength is selected.
	logic        keep, next_keep;       // DLL keep bit of mode register zero.

	// Computes the next helper values and the current latency.
	always_comb begin
		next_mr1 = (mrsValid && mrsSel == 2'h1) ? mrsData : mr1;
		next_mr2 = (mrsValid && mrsSel == 2'h2) ? mrsData : mr2;
		next_keep = (mrsValid && mrsSel == 2'h0) ? mrsData[12] : keep;
		next_pinHist = {pinHist[14:0], termPin};
		next_wrHist = {wrHist[14:0], writeCmd};
		next_sinceWr = writeCmd ? 8'h00 : ((sinceWr == 8'hFF) ? sinceWr : sinceWr + 8'h01);
		lat = 32'(mr2[5:3]) + 3 + (dllFrozen && !keep ? 0 : 32'(mr1[4:3]));
		nomOn = mr1[9] | mr1[6] | mr1[2];
	end

	// Registers the helper values.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{mr1, mr2, pinHist, wrHist} <= '0;
			sinceWr <= 8'hFF;
			keep <= 1'b0;
		end else begin
			{mr1, mr2, pinHist, wrHist} <= {next_mr1, next_mr2, next_pinHist, next_wrHist};
			sinceWr <= next_sinceWr;
			keep <= next_keep;
		end
	end

	// ==================================================================
	// Controller side
	// ==================================================================
	property p_hold_assert;
		@(posedge clk) disable iff (!rstn) $rose(termPin) |-> termPin [*4];
	endproperty
	a_hold_assert: assert property (p_hold_assert) else $error("pin dropped early");
	property p_hold_full;
		@(posedge clk) disable iff (!rstn) writeCmd && termPin && !chopFour |-> termPin [*6];
	endproperty
	a_hold_full: assert property (p_hold_full) else $error("pin dropped after write");
	property p_hold_chop;
		@(posedge clk) disable iff (!rstn) writeCmd && termPin && chopFour |-> termPin [*4];
	endproperty
	a_hold_chop: assert property (p_hold_chop) else $error("pin dropped after chop");
	property p_read_pin_low;
		@(posedge clk) disable iff (!rstn) readCmd |-> !termPin;
	endproperty
	a_read_pin_low: assert property (p_read_pin_low) else $error("pin high at read");

	// ==================================================================
	// Device side
	// ==================================================================
	property p_on_follows_pin;
		@(posedge clk) disable iff (!rstn) termOn |-> pinHist[lat];
	endproperty
	a_on_follows_pin: assert property (p_on_follows_pin) else $error("on without pin");
	property p_on_latency;
		@(posedge clk) disable iff (!rstn)
		pinHist[lat] && nomOn && !dllOff && !$past(dllOff) && !readDriving && !$past(readDriving)
		|-> termOn;
	endproperty
	a_on_latency: assert property (p_on_latency) else $error("on missing");
	property p_read_off;
		@(posedge clk) disable iff (!rstn) readDriving ##1 readDriving |-> !termOn;
	endproperty
	a_read_off: assert property (p_read_off) else $error("on while driving");
	property p_dll_off;
		@(posedge clk) disable iff (!rstn) dllOff ##1 dllOff |-> !termOn;
	endproperty
	a_dll_off: assert property (p_dll_off) else $error("on with dll off");
	property p_wr_start;
		@(posedge clk) disable iff (!rstn)
		strength == term_ctrl_pkg::STR_WRITE && $past(strength) == term_ctrl_pkg::STR_NOMINAL
		|-> wrHist[lat];
	endproperty
	a_wr_start: assert property (p_wr_start) else $error("write strength mistimed");
	property p_nominal_idle;
		@(posedge clk) disable iff (!rstn)
		32'(sinceWr) > lat + 7 && termOn |-> strength == term_ctrl_pkg::STR_NOMINAL;
	endproperty
	a_nominal_idle: assert property (p_nominal_idle) else $error("not nominal");
endmodule : dram_on_die_termination_ctrl_props
`default_nettype wire

// ==== verification/dram_on_die_termination_ctrl_test.sv ====
// Testbench joining both ends and driving the controller over APB.
`timescale 1ns/100ps
`default_nettype none
module dram_on_die_termination_ctrl_test;
	// ==================================================================
	// Signals
	// ==================================================================
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, readDriving, termOn, rerr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [2:0]  nomSel;
	logic [1:0]  wrSel;
	term_ctrl_pkg::strength_e strength;
	int failCount, checkCount, n, a, b;
	term_link_if link ();

	dram_term_ctrl dram_term_ctrl_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	dram_term_device dram_term_device_inst (.clk(clk), .rstn(rstn), .link(link),
		.readDriving(readDriving), .termOn(termOn), .strength(strength), .nomSel(nomSel),
		.wrSel(wrSel));
	dram_on_die_termination_ctrl_props dram_on_die_termination_ctrl_props_inst (.clk(clk),
		.rstn(rstn), .termPin(link.termPin), .writeCmd(link.writeCmd), .readCmd(link.readCmd),
		.chopFour(link.chopFour), .mrsValid(link.mrsValid), .mrsSel(link.mrsSel),
		.mrsData(link.mrsData), .dllFrozen(link.dllFrozen), .dllOff(link.dllOff),
		.readDriving(readDriving), .termOn(termOn), .strength(strength));

	// The clock toggles every 2.5 ns, a period of 5 ns.
	always #2.5 clk = ~clk;

	// ==================================================================
	// Shared tasks
	// ==================================================================
	// Counts one comparison and any mismatch.
	function automatic bit ok(input logic c);
		checkCount++;
		if (c !== 1'b1) begin
			failCount++;
		end
		return c === 1'b1;
	endfunction : ok

	// One APB transfer; read data and error are taken at the accepting edge.
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Counts edges from the pin reaching a level to termination following it.
	task automatic measure(input logic lvl, output int cnt);
		cnt = 0;
		while (link.termPin !== lvl) @(posedge clk);
		while (termOn !== lvl && cnt < 64) begin
			@(posedge clk);
			cnt++;
		end
	endtask : measure

	// Counts edges until the reported strength takes a value.
	task automatic reach(input term_ctrl_pkg::strength_e s, inout int cnt);
		while (strength !== s && cnt < 64) begin
			@(posedge clk);
			cnt++;
		end
	endtask : reach

	// Sets the pin level through the command register and lets the line settle.
	task automatic pin(input logic lvl, input int expect_n);
		apb(1'b1, term_ctrl_pkg::REG_CMD, lvl ? 32'h00000026 : 32'h00000006);
		measure(lvl, n);
		if (!ok(n == expect_n)) $display("unexpected at %0t: pin to termination delay", $time);
		repeat (16) @(posedge clk);
	endtask : pin

	// ==================================================================
	// Scenarios
	// ==================================================================
	// Mode registers, unmapped access and decoded strength selects.
	task automatic testRegs;
		apb(1'b1, 8'h18, 32'hFFFFFFFF);
		if (!ok(rerr === 1'b1)) $display("unexpected at %0t: no slave error", $time);
		apb(1'b1, term_ctrl_pkg::REG_MR0, 32'h00001000);
		apb(1'b1, term_ctrl_pkg::REG_CMD, 32'h00000003);
		apb(1'b1, term_ctrl_pkg::REG_MR1, 32'h00000214);
		apb(1'b0, term_ctrl_pkg::REG_MR1, 32'h00000000);
		if (!ok(rdata === 32'h00000214)) $display("unexpected at %0t: mode one readback", $time);
		apb(1'b1, term_ctrl_pkg::REG_CMD, 32'h00000004);
		apb(1'b1, term_ctrl_pkg::REG_MR2, 32'h00000208);
		apb(1'b1, term_ctrl_pkg::REG_CMD, 32'h00000005);
		repeat (4) @(posedge clk);
		if (!ok(nomSel === 3'b101)) $display("unexpected at %0t: nominal select", $time);
		if (!ok(wrSel === 2'b01)) $display("unexpected at %0t: write select", $time);
	endtask : testRegs

	// Latency with additive latency, also while frozen with the keep bit set, then without it once that bit is cleared.
	task automatic testLatency;
		pin(1'b1, 7);
		if (!ok(strength === term_ctrl_pkg::STR_NOMINAL)) $display("unexpected at %0t: strength", $time);
		pin(1'b0, 7);
		apb(1'b1, term_ctrl_pkg::REG_CTRL, 32'h00000002);
		pin(1'b1, 7);
		pin(1'b0, 7);
		apb(1'b1, term_ctrl_pkg::REG_MR0, 32'h00000000);
		apb(1'b1, term_ctrl_pkg::REG_CMD, 32'h00000003);
		pin(1'b1, 5);
		pin(1'b0, 5);
		apb(1'b1, term_ctrl_pkg::REG_CTRL, 32'h00000000);
		repeat (16) @(posedge clk);
	endtask : testLatency

	// Full and chopped writes switch strength and return to nominal.
	task automatic testWrite;
		for (int chop = 0; chop < 2; chop++) begin
			pin(1'b1, 7);
			apb(1'b1, term_ctrl_pkg::REG_CMD, chop ? 32'h00000011 : 32'h00000001);
			while (link.writeCmd !== 1'b1) @(posedge clk);
			a = 0;
			reach(term_ctrl_pkg::STR_WRITE, a);
			b = a;
			reach(term_ctrl_pkg::STR_NOMINAL, b);
			if (!ok(a == 7)) $display("unexpected at %0t: write strength", $time);
			if (!ok(b - a == (chop ? 4 : 6))) $display("unexpected at %0t: back to nominal", $time);
			pin(1'b0, 7);
		end
	endtask : testWrite

	// Termination gives way while the device drives read data.
	task automatic testRead;
		pin(1'b1, 7);
		apb(1'b1, term_ctrl_pkg::REG_CMD, 32'h00000002);
		readDriving <= 1'b1;
		repeat (3) @(posedge clk);
		if (!ok(termOn === 1'b0)) $display("unexpected at %0t: on while driving", $time);
		readDriving <= 1'b0;
		repeat (8) @(posedge clk);
		if (!ok(link.termPin === 1'b0 && termOn === 1'b0)) $display("unexpected at %0t: pin kept at read", $time);
	endtask : testRead

	// With the DLL off no termination and no write strength remain.
	task automatic testDllOff;
		apb(1'b1, term_ctrl_pkg::REG_CTRL, 32'h00000001);
		apb(1'b1, term_ctrl_pkg::REG_CMD, 32'h00000026);
		repeat (12) @(posedge clk);
		if (!ok(termOn === 1'b0)) $display("unexpected at %0t: on with dll off", $time);
		apb(1'b0, term_ctrl_pkg::REG_MR2, 32'h00000000);
		if (!ok(rdata[10:9] === 2'b00)) $display("unexpected at %0t: write bits kept", $time);
		if (!ok(wrSel === 2'b00)) $display("unexpected at %0t: write select kept", $time);
		apb(1'b1, term_ctrl_pkg::REG_CMD, 32'h00000006);
	endtask : testDllOff

	// Prints the counts and the verdict, then ends the run.
	task automatic testDone;
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : testDone

	// Main sequence after a reset of six clocks.
	initial begin
		{clk, rstn, psel, penable, pwrite, readDriving} = '0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		failCount = 0;
		checkCount = 0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		testRegs();
		testLatency();
		testWrite();
		testRead();
		testDllOff();
		testDone();
	end

	// Watchdog cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		failCount++;
		testDone();
	end
endmodule : dram_on_die_termination_ctrl_test
`default_nettype wire
